// ---- bench/twi_ctl_model.sv ----
/*
 * controller-receiver model for the two-wire target bench.
 * assumes the bench resolves both lines with pull-ups from all pull-downs.
 */
`timescale 1ns/100ps
module twi_ctl_model (
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // pull-downs and status
    output logic scl_pull,
    output logic sda_pull,
    output logic stalled
);
    // ********************************
    // bus conditions and bits, 160 ns per bit
    // ********************************
    localparam int Q = 40;
    initial begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
        stalled = 1'h0;
    end
    task automatic go_start();
        sda_pull = 1'h1;
        #Q scl_pull = 1'h1;
        #Q;
    endtask
    task automatic go_stop();
        sda_pull = 1'h1;
        #Q scl_pull = 1'h0;
        #Q sda_pull = 1'h0;
        #Q;
    endtask
    // a held clock is waited out, never overridden
    task automatic bit_io(input logic b, output logic r);
        int n;
        n = 0;
        sda_pull = !b;
        #Q scl_pull = 1'h0;
        while (scl !== 1'h1 && n < 20000) begin
            #20;
            n++;
        end
        if (n >= 20000) stalled = 1'h1;
        #Q r = sda;
        #Q scl_pull = 1'h1;
        #Q;
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'h1, r);
        ack = !r;
    endtask
    // ack asks for more, nack ends the read
    task automatic get_byte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            v[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule // twi_ctl_model

// ---- bench/twi_target_tx_tb_top.sv ----
/*
 * bench for the two-wire target transmitter: register bus master,
 * software sequences and a controller model on pulled-up lines.
 */
`timescale 1ns/100ps
module twi_target_tx_tb_top import twi_tgt_pkg::*; ();
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] ctrl;
        logic ack;
    } row_t;
    logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ak, watch;
    logic [7:0] awaddr, araddr, v;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, stalled;
    logic sleep_deep, arb_lost, wake_req, start_req, rx_mode_start;
    int error_cnt, tests_run, rx_cnt, sda_cnt;
    wire scl = !((scl_oe && !scl_o) || scl_pull);
    wire sda = !((sda_oe && !sda_o) || sda_pull);
    row_t rows [3] = '{'{CODE_READ_ACK, 8'hA6, 8'hC4, 1'h1},
        '{CODE_DATA_ACK, 8'h5A, 8'hC4, 1'h1}, '{CODE_DATA_ACK, 8'h81, 8'h84, 1'h1}};
    twi_target_tx i_dut (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .sleep_deep(sleep_deep),
        .arb_lost(arb_lost), .wake_req(wake_req), .start_req(start_req),
        .rx_mode_start(rx_mode_start));
    twi_ctl_model i_ctl (.scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .stalled(stalled));
    // ********************************
    // clock, monitors and shared tasks
    // ********************************
    initial begin
        clk = 1'h0;
        forever #10 clk = !clk;
    end
    always @(posedge clk) begin
        if (rx_mode_start === 1'h1) rx_cnt++;
        if (watch && sda_oe === 1'h1) sda_cnt++;
    end
    task automatic end_sim();
        $display("counts: %0d compared, %0d bad", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // handshakes are judged just before the edge, released on it
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'h0;
        @(posedge clk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        while (!tb) begin
            @(negedge clk);
            ta = wr ? (awvalid && awready === 1'h1) : (arvalid && arready === 1'h1);
            tw = wvalid && wready === 1'h1;
            tb = wr ? bvalid === 1'h1 : rvalid === 1'h1;
            rd = rdata;
            rs = wr ? bresp : rresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (ta) arvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) bready <= 1'h0;
            if (tb) rready <= 1'h0;
            n++;
            if (n > 100) begin
                error_cnt++;
                end_sim();
            end
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        axi(1'h0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic wait_flag();
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[CB_FLAG] !== 1'h1) begin
            axi(1'h0, OFS_CTRL, 32'h0);
            n++;
            if (n > 400) begin
                error_cnt++;
                end_sim();
            end
        end
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready, sleep_deep, arb_lost} = 8'h0;
        {awaddr, araddr, wdata, rd} = 80'h0;
        wstrb = 4'hF;
        {watch, error_cnt, tests_run, rx_cnt, sda_cnt} = 129'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        axi(1'h1, OFS_OWN, 32'h50);
        check(rs, RESP_OKAY);
        axi(1'h1, OFS_CTRL, 32'h04);
        i_ctl.go_start();
        i_ctl.put_byte(8'h51, ak);
        check(ak, 32'h0);
        i_ctl.go_stop();
        axi(1'h1, OFS_CTRL, 32'h44);
        i_ctl.go_start();
        i_ctl.put_byte(8'h00, ak);
        check(ak, 32'h0);
        i_ctl.go_stop();
        axi(1'h1, OFS_OWN, 32'h51);
        i_ctl.go_start();
        i_ctl.put_byte(8'h00, ak);
        check(ak, 32'h1);
        i_ctl.go_stop();
        rx_cnt = 0;
        i_ctl.go_start();
        i_ctl.put_byte(8'h50, ak);
        check(ak, 32'h1);
        i_ctl.go_stop();
        check(rx_cnt, 32'h1);
        $display("address tests done");
        i_ctl.go_start();
        i_ctl.put_byte(8'h51, ak);
        check(ak, 32'h1);
        for (int i = 0; i < 3; i++) begin
            fork
                i_ctl.get_byte(rows[i].ack, v);
                begin
                    wait_flag();
                    check(scl_oe, 32'h1);
                    rdc(OFS_CODE, rows[i].code);
                    axi(1'h1, OFS_DATA, rows[i].data);
                    axi(1'h1, OFS_CTRL, rows[i].ctrl);
                end
            join
            check(v, rows[i].data);
        end
        wait_flag();
        rdc(OFS_CODE, CODE_LAST_ACK);
        axi(1'h1, OFS_CTRL, 32'hC4);
        watch = 1'h1;
        i_ctl.get_byte(1'h0, v);
        check(v, 32'hFF);
        check(sda_cnt, 32'h0);
        watch = 1'h0;
        i_ctl.go_stop();
        $display("read transfer test done");
        // lost arbitration in deep sleep, last byte refused by nack
        @(posedge clk);
        arb_lost <= 1'h1;
        sleep_deep <= 1'h1;
        i_ctl.go_start();
        i_ctl.put_byte(8'h51, ak);
        check(ak, 32'h1);
        wait_flag();
        rdc(OFS_CODE, CODE_ARB_READ);
        check(wake_req, 32'h1);
        check(scl_oe, 32'h1);
        rdc(OFS_AUX, 32'h3);
        @(posedge clk);
        arb_lost <= 1'h0;
        sleep_deep <= 1'h0;
        fork
            i_ctl.get_byte(1'h0, v);
            begin
                axi(1'h1, OFS_DATA, 32'h3C);
                axi(1'h1, OFS_CTRL, 32'hA4);
            end
        join
        check(v, 32'h3C);
        check(wake_req, 32'h0);
        wait_flag();
        rdc(OFS_CODE, CODE_DATA_NACK);
        check(start_req, 32'h0);
        i_ctl.go_stop();
        repeat (8) @(posedge clk);
        check(start_req, 32'h1);
        axi(1'h1, OFS_CTRL, 32'hC4);
        check(start_req, 32'h0);
        $display("arbitration and wake test done");
        axi(1'h1, 8'h14, 32'h0);
        check(rs, RESP_SLVERR);
        rdc(8'h14, 32'h0);
        check(rs, RESP_SLVERR);
        @(posedge clk);
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        rdc(OFS_OWN, OWN_RESET);
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_DATA, DATA_RESET);
        rdc(OFS_CODE, CODE_NONE);
        rdc(OFS_AUX, 32'h0);
        check(stalled, 32'h0);
        $display("bus error and reset test done");
        end_sim();
    end
endmodule // twi_target_tx_tb_top

// ---- hdl/twi_pin_sync.sv ----
/*
 * two-flop synchroniser with edge detection for bus pins.
 * assumes idle-high open-drain lines; resets to high so no false edges.
 */
`timescale 1ns/100ps
module twi_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins in, synchronised view out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] m;
        logic [W-1:0] q;
        logic [W-1:0] p;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.m = pin_in;
        s_nxt.q = s_r.m;
        s_nxt.p = s_r.q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // edges look only at the second and third flops
    assign lvl = s_r.q;
    assign rise = s_r.q & ~s_r.p;
    assign fall = ~s_r.q & s_r.p;
endmodule // twi_pin_sync

// ---- hdl/twi_target_tx.sv ----
/*
 * two-wire target-transmitter with AXI4-Lite register access.
 * assumes open-drain pins resolved outside, a controller block supplying
 * arb_lost, and a receiver block taking over on rx_mode_start.
 */
// Function
// - event codes read with prescaler bits forced to zero.
// - answer the seven-bit own address in own-address bits 7..1.
// - answer general call only when own-address bit 0 is one; also answered here when own-address bits 7..1 are zero.
// - read direction enters transmit, write direction hands to receive.
// - own address with read direction sets event flag and a valid code.
// - addressed for read after lost arbitration reports its own code.
// - acknowledge enable cleared makes the current byte the last.
// - after the last byte report nack or ack with distinct codes.
// - after the last byte go not-addressed, leave data line released.
// - acknowledge enable zero ignores own address but keeps monitoring.
// - in deep sleep still recognise and acknowledge own address.
// - sleep match with read direction requests wake and holds clock low until flag cleared.
// - data register content is stale after waking.
// - after read address software loads data and clears flag.
// - after lost arbitration read, load data and clear flag likewise.
// - sent byte acknowledged reports data-acked code, then next byte.
// - after nack go not-addressed; begin request starts when bus free.
`timescale 1ns/100ps
module twi_target_tx
    import twi_tgt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // two-wire pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // system side
    input wire logic sleep_deep,
    input wire logic arb_lost,
    output logic wake_req,
    output logic start_req,
    output logic rx_mode_start
);
    typedef struct packed {
        state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] own;
        logic ack_en;
        logic begin_req;
        logic end_req;
        logic en;
        logic flag;
        logic [7:0] code;
        logic [7:0] data;
        logic last;
        logic ackd;
        logic rd;
        logic wake;
        logic rxs;
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [7:0] w_d;
        logic w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd_d;
        logic [1:0] rr;
    } core_t;

    core_t s_r;
    core_t s_nxt;
    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic hit;

    twi_pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in({sda_i, scl_i}),
        .lvl(lvl),
        .rise(rise),
        .fall(fall)
    );

    assign scl = lvl[0];
    assign sda = lvl[1];
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign bus_start = fall[1] & scl;
    assign bus_stop = rise[1] & scl;
    // own address or enabled general call
    assign hit = (s_r.sh[7:1] == s_r.own[7:1])
        || (s_r.own[OWN_GC_BIT] && (s_r.sh[7:1] == 7'h00));

    // ********************************
    // bus handshakes and pin drive
    // ********************************
    assign awready = !s_r.aw_v && !s_r.bv;
    assign wready = !s_r.w_v && !s_r.bv;
    assign arready = !s_r.rv;
    assign bvalid = s_r.bv;
    assign bresp = s_r.br;
    assign rvalid = s_r.rv;
    assign rdata = s_r.rd_d;
    assign rresp = s_r.rr;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // a long wake-up holds the clock low and blocks other traffic
    assign scl_oe = (s_r.st == ST_TXW) || (s_r.wake && s_r.flag);
    // data line released outside address ack and zero data bits
    assign sda_oe = (s_r.st == ST_AACK)
        || (((s_r.st == ST_TXB) || ((s_r.st == ST_TXW) && !s_r.flag)) && !s_r.sh[7]);
    assign wake_req = s_r.wake;
    assign start_req = s_r.en && s_r.begin_req && (s_r.st == ST_IDLE) && scl && sda;
    assign rx_mode_start = s_r.rxs;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rxs = 1'b0;

        // ********************************
        // register access
        // ********************************
        if (awvalid && awready) begin
            s_nxt.aw_v = 1'b1;
            s_nxt.aw_a = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_v = 1'b1;
            s_nxt.w_d = wdata[7:0];
            s_nxt.w_s = wstrb[0];
        end
        if (s_r.bv && bready) begin
            s_nxt.bv = 1'b0;
        end
        if (s_r.aw_v && s_r.w_v) begin
            s_nxt.aw_v = 1'b0;
            s_nxt.w_v = 1'b0;
            s_nxt.bv = 1'b1;
            s_nxt.br = RESP_OKAY;
            case (s_r.aw_a)
                OFS_OWN: begin
                    if (s_r.w_s) s_nxt.own = s_r.w_d;
                end
                OFS_CTRL: begin
                    if (s_r.w_s) begin
                        s_nxt.ack_en = s_r.w_d[CB_ACKEN];
                        s_nxt.begin_req = s_r.w_d[CB_BEGIN];
                        s_nxt.end_req = s_r.w_d[CB_END];
                        s_nxt.en = s_r.w_d[CB_EN];
                        // writing one clears the flag
                        if (s_r.w_d[CB_FLAG]) s_nxt.flag = 1'b0;
                    end
                end
                // software-only data; the bus never refreshes it, stale after wake
                OFS_DATA: begin
                    if (s_r.w_s) s_nxt.data = s_r.w_d;
                end
                OFS_CODE, OFS_AUX: begin
                end
                default: s_nxt.br = RESP_SLVERR;
            endcase
        end
        if (s_r.rv && rready) begin
            s_nxt.rv = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.rv = 1'b1;
            s_nxt.rr = RESP_OKAY;
            s_nxt.rd_d = 32'h0000_0000;
            case (araddr)
                OFS_OWN: s_nxt.rd_d[7:0] = s_r.own;
                OFS_CTRL: s_nxt.rd_d[7:0] = {s_r.flag, s_r.ack_en, s_r.begin_req, s_r.end_req,
                    1'b0, s_r.en, 2'h0};
                OFS_CODE: s_nxt.rd_d[7:0] = s_r.code & CODE_MASK;
                OFS_DATA: s_nxt.rd_d[7:0] = s_r.data;
                OFS_AUX: s_nxt.rd_d[1:0] = {sleep_deep, s_r.wake};
                default: s_nxt.rr = RESP_SLVERR;
            endcase
        end

        // ********************************
        // serial engine; hardware set wins over software clear
        // ********************************
        if (!s_r.en) begin
            s_nxt.st = ST_IDLE;
        end else if (bus_start) begin
            s_nxt.st = ST_ADDR;
            s_nxt.cnt = 4'h0;
        end else if (bus_stop) begin
            s_nxt.st = ST_IDLE;
        end else begin
            case (s_r.st)
                ST_ADDR: begin
                    if (scl_rise) begin
                        s_nxt.sh = {s_r.sh[6:0], sda};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                    // monitoring goes on with ack disabled; next start re-arms
                    if (scl_fall && (s_r.cnt == ADDR_BITS)) begin
                        if (hit && s_r.ack_en) begin
                            s_nxt.st = ST_AACK;
                            s_nxt.rd = s_r.sh[0];
                        end else begin
                            s_nxt.st = ST_NADR;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (s_r.rd) begin
                            s_nxt.st = ST_TXW;
                            s_nxt.flag = 1'b1;
                            s_nxt.code = arb_lost ? CODE_ARB_READ : CODE_READ_ACK;
                            if (sleep_deep) s_nxt.wake = 1'b1;
                        end else begin
                            s_nxt.st = ST_NADR;
                            s_nxt.rxs = 1'b1;
                        end
                    end
                end
                ST_TXW: begin
                    // first bit settles a cycle before the clock is let go, so no false start
                    s_nxt.sh = s_r.data;
                    if (!s_r.flag) begin
                        s_nxt.st = ST_TXB;
                        s_nxt.last = !s_r.ack_en;
                        s_nxt.cnt = 4'h0;
                        s_nxt.wake = 1'b0;
                    end
                end
                ST_TXB: begin
                    if (scl_fall) begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                        s_nxt.sh = {s_r.sh[6:0], 1'b1};
                        if (s_r.cnt == LAST_BIT) s_nxt.st = ST_TXA;
                    end
                end
                ST_TXA: begin
                    if (scl_rise) s_nxt.ackd = !sda;
                    if (scl_fall) begin
                        s_nxt.flag = 1'b1;
                        if (!s_r.ackd) begin
                            s_nxt.code = CODE_DATA_NACK;
                            s_nxt.st = ST_NADR;
                        end else if (s_r.last) begin
                            s_nxt.code = CODE_LAST_ACK;
                            s_nxt.st = ST_NADR;
                        end else begin
                            s_nxt.code = CODE_DATA_ACK;
                            s_nxt.st = ST_TXW;
                        end
                    end
                end
                ST_NADR, ST_IDLE: begin
                end
                default: s_nxt.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.own <= OWN_RESET;
            s_r.data <= DATA_RESET;
            s_r.code <= CODE_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_wait_stretch: assert property ((s_r.st == ST_TXW) |-> scl_oe)
        else $error("clock not held while flag set");
    a_data_setup: assert property (($fell(scl_oe) && s_r.st == ST_TXB)
        |-> $stable(sda_oe))
        else $error("data bit changed as clock released");
    a_sleep_hold: assert property ((s_r.wake && s_r.flag) |-> scl_oe)
        else $error("clock released during wake");
    a_addr_ack: assert property ((s_r.st == ST_AACK) |-> sda_oe)
        else $error("address not acknowledged");
    a_nadr_release: assert property ((s_r.st == ST_NADR) |-> !sda_oe)
        else $error("data line driven when not addressed");
    a_ack_off: assert property ((s_r.st == ST_ADDR && scl_fall && s_r.cnt == ADDR_BITS
        && s_r.en && !bus_start && !bus_stop && !s_r.ack_en) |=> (s_r.st == ST_NADR))
        else $error("answered with ack disabled");
    a_gc_ignored: assert property ((s_r.st == ST_ADDR && s_r.sh[7:1] == 7'h00
        && s_r.own[7:1] != 7'h00 && !s_r.own[OWN_GC_BIT] && s_r.cnt == ADDR_BITS)
        |-> !(s_nxt.st == ST_AACK))
        else $error("general call answered while disabled");
    a_read_code: assert property ((s_r.st == ST_AACK && scl_fall && s_r.rd && s_r.en
        && !bus_start && !bus_stop) |=> (s_r.flag && s_r.st == ST_TXW
        && (s_r.code == CODE_READ_ACK || s_r.code == CODE_ARB_READ)))
        else $error("read address event not reported");
    a_arb_code: assert property ((s_r.st == ST_AACK && scl_fall && s_r.rd && arb_lost
        && s_r.en && !bus_start && !bus_stop) |=> (s_r.code == CODE_ARB_READ))
        else $error("lost arbitration code wrong");
    a_last_code: assert property ((s_r.st == ST_TXA && scl_fall && s_r.en && !bus_start
        && !bus_stop && s_r.last && s_r.ackd) |=> (s_r.code == CODE_LAST_ACK
        && s_r.st == ST_NADR))
        else $error("last byte ack code wrong");
    a_more_code: assert property ((s_r.st == ST_TXA && scl_fall && s_r.en && !bus_start
        && !bus_stop && !s_r.last && s_r.ackd) |=> (s_r.code == CODE_DATA_ACK))
        else $error("data ack code wrong");
    a_code_read: assert property ((arvalid && arready && araddr == OFS_CODE)
        |=> (rdata[2:0] == 3'h0))
        else $error("prescaler bits not zero");

    c_byte_sent: cover property (s_r.st == ST_TXA ##1 s_r.code == CODE_DATA_ACK);
    c_last_ack: cover property (s_r.code == CODE_LAST_ACK);
    c_nack: cover property (s_r.code == CODE_DATA_NACK);
    c_wake: cover property (s_r.wake && scl_oe);
endmodule // twi_target_tx

// ---- hdl/twi_tgt_pkg.sv ----
/*
 * constants for the two-wire target-transmitter block: register offsets,
 * control bit positions, event codes, reset values and state codes.
 * assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package twi_tgt_pkg;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] OFS_OWN = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_CODE = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_AUX = 8'h10;

    // ********************************
    // control, own-address and aux fields
    // ********************************
    localparam int CB_FLAG = 7;
    localparam int CB_ACKEN = 6;
    localparam int CB_BEGIN = 5;
    localparam int CB_END = 4;
    localparam int CB_EN = 2;
    localparam int OWN_GC_BIT = 0;
    localparam int AUX_WAKE = 0;
    localparam int AUX_SLEEP = 1;

    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] OWN_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ********************************
    // event codes, prescaler field read as zero
    // ********************************
    localparam logic [7:0] CODE_NONE = 8'hF8;
    localparam logic [7:0] CODE_READ_ACK = 8'hA8;
    localparam logic [7:0] CODE_ARB_READ = 8'hB0;
    localparam logic [7:0] CODE_DATA_ACK = 8'hB8;
    localparam logic [7:0] CODE_DATA_NACK = 8'hC0;
    localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
    localparam logic [7:0] CODE_MASK = 8'hF8;

    // ********************************
    // bus responses and bit counts
    // ********************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] ADDR_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_TXW = 7'h08,
        ST_TXB = 7'h10,
        ST_TXA = 7'h20,
        ST_NADR = 7'h40
    } state_t;

endpackage
